// [design/cfg_regs_pkg.sv]
// package for the pin-zero, queue threshold and sync word register bank
// assumes an eight-bit serial configuration port with six-bit addresses
package cfg_regs_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [5:0] PIN_ZERO_OUTPUT_CONFIG_OFS = 6'h02;
    localparam logic [5:0] QUEUE_THRESHOLD_CONFIG_OFS = 6'h03;
    localparam logic [5:0] SYNC_WORD_HIGH_BYTE_OFS    = 6'h04;
    localparam logic [5:0] SYNC_WORD_LOW_BYTE_OFS     = 6'h05;

    // ************************************************************
    // reset values and field positions
    // ************************************************************
    localparam logic [7:0] PIN_ZERO_OUTPUT_CONFIG_RST = 8'h3f;
    localparam logic [7:0] QUEUE_THRESHOLD_CONFIG_RST = 8'h07;
    localparam logic [7:0] SYNC_WORD_HIGH_BYTE_RST    = 8'hd3;
    localparam logic [7:0] SYNC_WORD_LOW_BYTE_RST     = 8'h91;
    localparam int         TEMP_SENSOR_BIT            = 7;
    localparam int         POLARITY_BIT               = 6;
    localparam int         SELECT_MSB                 = 5;
    localparam int         THRESHOLD_MSB              = 3;
    localparam logic [7:0] THRESHOLD_FIELD_MASK       = 8'h0f;
    localparam logic [7:0] UNMAPPED_READ              = 8'h00;

    // ************************************************************
    // queue threshold arithmetic, counts in bytes
    // ************************************************************
    localparam logic [6:0] TX_THRESHOLD_BASE = 7'h3d;  // 61 bytes
    localparam logic [6:0] THRESHOLD_STEP    = 7'h04;
    localparam logic [6:0] QUEUE_DEPTH       = 7'h40;  // 64 bytes

    // ************************************************************
    // crystal clock divider feeding select code 63
    // ************************************************************
    localparam int         CRYSTAL_DIVIDE = 192;
    localparam logic [6:0] DIV_HALF_LAST  = 7'(CRYSTAL_DIVIDE / 2 - 1);

    // ************************************************************
    // serial header byte layout
    // ************************************************************
    localparam int         HDR_READ_BIT  = 7;
    localparam int         HDR_BURST_BIT = 6;
    localparam logic [2:0] LAST_BIT      = 3'h7;

endpackage

// [design/cfg_port_if.sv]
// carrier between the serial port engine and the register bank
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface cfg_port_if;
    logic       wr_en;    // one-cycle write strobe
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic [5:0] rd_addr;  // combinational read address
    logic [7:0] rd_data;  // combinational read answer

    modport port (output wr_en, wr_addr, wr_data, rd_addr,
                  input  rd_data);
    modport bank (input  wr_en, wr_addr, wr_data, rd_addr,
                  output rd_data);
endinterface

// [design/serial_port_engine.sv]
// serial configuration port engine: header byte, then data bytes
// assumes mode 0 framing: sample on rising edge, shift on falling edge
`timescale 1ns/1ns
module serial_port_engine (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pins, asynchronous to clk
    input  wire logic port_sclk,
    input  wire logic port_cs_n,
    input  wire logic port_mosi,
    output logic      port_miso,
    output logic      port_miso_oe,
    // bank side
    cfg_port_if.port  bus
);

    typedef enum logic {st_header, st_data} phase_t;

    // ************************************************************
    // pin synchronisers: bit 0 sclk, bit 1 cs_n, bit 2 mosi
    // ************************************************************
    logic [2:0] meta_q, sync_q, meta_d, sync_d;
    logic       sclk_prev_q, sclk_prev_d;

    always_comb begin
        meta_d      = {port_mosi, port_cs_n, port_sclk};
        sync_d      = meta_q;
        sclk_prev_d = sync_q[0];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q      <= 3'h2;  // idle: cs_n high, sclk low as in mode 0
            sync_q      <= 3'h2;
            sclk_prev_q <= 1'b0;  // no false edge once reset lets go
        end else begin
            meta_q      <= meta_d;
            sync_q      <= sync_d;
            sclk_prev_q <= sclk_prev_d;
        end
    end

    logic active, rise, fall;
    logic [7:0] byte_in;
    assign active  = ~sync_q[1];
    assign rise    = sync_q[0] & ~sclk_prev_q;
    assign fall    = ~sync_q[0] & sclk_prev_q;

    // ************************************************************
    // framing state
    // ************************************************************
    phase_t     phase_q, phase_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] shin_q, shin_d, tx_q, tx_d, wdata_q, wdata_d;
    logic [5:0] addr_q, addr_d, waddr_q, waddr_d;
    logic       rd_q, rd_d, burst_q, burst_d, wr_q, wr_d, oe_q, oe_d;

    assign byte_in = {shin_q[6:0], sync_q[2]};

    // next-state: chip select high resets framing; a single access also ends after its data byte
    always_comb begin
        phase_d = phase_q;
        bit_d   = bit_q;
        shin_d  = shin_q;
        tx_d    = tx_q;
        addr_d  = addr_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        rd_d    = rd_q;
        burst_d = burst_q;
        wr_d    = 1'b0;
        oe_d    = active;
        if (!active) begin
            phase_d = st_header;
            bit_d   = 3'h0;
            tx_d    = 8'h00;
        end else if (rise) begin
            shin_d = byte_in;
            bit_d  = bit_q + 3'h1;
            if (bit_q == cfg_regs_pkg::LAST_BIT) begin
                unique case (phase_q)
                    st_header: begin
                        addr_d  = byte_in[5:0];
                        rd_d    = byte_in[cfg_regs_pkg::HDR_READ_BIT];
                        burst_d = byte_in[cfg_regs_pkg::HDR_BURST_BIT];
                        phase_d = st_data;
                        tx_d    = rd_d ? bus.rd_data : 8'h00;
                    end
                    st_data: begin
                        wr_d    = ~rd_q;
                        waddr_d = addr_q;
                        wdata_d = byte_in;
                        if (burst_q) begin
                            addr_d = addr_q + 6'h01;  // wraps in 64
                        end else begin
                            phase_d = st_header;  // single access done
                        end
                        tx_d = (rd_q && burst_q) ? bus.rd_data : 8'h00;
                    end
                endcase
            end
        end else if (fall && bit_q != 3'h0) begin
            tx_d = {tx_q[6:0], 1'b0};  // first bit stays up a full cycle
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= st_header;
            bit_q   <= 3'h0;
            shin_q  <= 8'h00;
            tx_q    <= 8'h00;
            addr_q  <= 6'h00;
            waddr_q <= 6'h00;
            wdata_q <= 8'h00;
            rd_q    <= 1'b0;
            burst_q <= 1'b0;
            wr_q    <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            phase_q <= phase_d;
            bit_q   <= bit_d;
            shin_q  <= shin_d;
            tx_q    <= tx_d;
            addr_q  <= addr_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            rd_q    <= rd_d;
            burst_q <= burst_d;
            wr_q    <= wr_d;
            oe_q    <= oe_d;
        end
    end

    // bank reads ahead with the next address so data loads in one edge
    assign bus.rd_addr   = addr_d;
    assign bus.wr_en     = wr_q;
    assign bus.wr_addr   = waddr_q;
    assign bus.wr_data   = wdata_q;
    assign port_miso     = tx_q[7];
    assign port_miso_oe  = oe_q;

endmodule // serial_port_engine

// [design/pin0_fifo_threshold_sync_regs.sv]
// register bank: pin-zero output, queue thresholds and sync word
// assumes the host keeps its own duties on the serial port pins
//
// Operation
// - polarity bit 6 of pin-zero config inverts output; resets to 0.
// - select field bits 5:0 picks pin source; resets 0x3F, crystal/192.
// - threshold bits 7:4 reserved, read zero, reset zero; host writes zero.
// - four-bit threshold resets 7; tx is 61-4N, rx is 4(N+1).
// - threshold exceeded when queue count is equal or greater.
// - sync high byte holds word bits 15:8, read/write, resets 0xD3.
// - sync low byte holds word bits 7:0, read/write, resets 0x91.
`timescale 1ns/1ns
module pin0_fifo_threshold_sync_regs #(
    parameter int COUNT_W = 7
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // serial configuration port pins
    input  wire logic               port_sclk,
    input  wire logic               port_cs_n,
    input  wire logic               port_mosi,
    output logic                    port_miso,
    output logic                    port_miso_oe,
    // internal sources for select codes 0..62
    input  wire logic [62:0]        pin_sources,
    // queue fill levels in bytes
    input  wire logic [COUNT_W-1:0] tx_queue_count,
    input  wire logic [COUNT_W-1:0] rx_queue_count,
    // decoded configuration and status
    output logic                    general_output_pin_zero,
    output logic                    temp_sensor_enable,
    output logic [15:0]             sync_word,
    output logic [COUNT_W-1:0]      tx_threshold,
    output logic [COUNT_W-1:0]      rx_threshold,
    output logic                    tx_threshold_hit,
    output logic                    rx_threshold_hit
);

    cfg_port_if bus ();

    serial_port_engine u_port (
        .clk          (clk),
        .rst          (rst),
        .port_sclk    (port_sclk),
        .port_cs_n    (port_cs_n),
        .port_mosi    (port_mosi),
        .port_miso    (port_miso),
        .port_miso_oe (port_miso_oe),
        .bus          (bus.port)
    );

    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0] pin_cfg_q, pin_cfg_d, thr_cfg_q, thr_cfg_d;
    logic [7:0] sync_hi_q, sync_hi_d, sync_lo_q, sync_lo_d;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        return a == o;
    endfunction

    // writes land one edge after the strobe; unmapped writes dropped
    always_comb begin
        pin_cfg_d = pin_cfg_q;
        thr_cfg_d = thr_cfg_q;
        sync_hi_d = sync_hi_q;
        sync_lo_d = sync_lo_q;
        if (bus.wr_en) begin
            if (hit(bus.wr_addr, cfg_regs_pkg::PIN_ZERO_OUTPUT_CONFIG_OFS))
                pin_cfg_d = bus.wr_data;
            if (hit(bus.wr_addr, cfg_regs_pkg::QUEUE_THRESHOLD_CONFIG_OFS))
                thr_cfg_d = bus.wr_data
                          & cfg_regs_pkg::THRESHOLD_FIELD_MASK;
            if (hit(bus.wr_addr, cfg_regs_pkg::SYNC_WORD_HIGH_BYTE_OFS))
                sync_hi_d = bus.wr_data;
            if (hit(bus.wr_addr, cfg_regs_pkg::SYNC_WORD_LOW_BYTE_OFS))
                sync_lo_d = bus.wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_cfg_q <= cfg_regs_pkg::PIN_ZERO_OUTPUT_CONFIG_RST;
            thr_cfg_q <= cfg_regs_pkg::QUEUE_THRESHOLD_CONFIG_RST;
            sync_hi_q <= cfg_regs_pkg::SYNC_WORD_HIGH_BYTE_RST;
            sync_lo_q <= cfg_regs_pkg::SYNC_WORD_LOW_BYTE_RST;
        end else begin
            pin_cfg_q <= pin_cfg_d;
            thr_cfg_q <= thr_cfg_d;
            sync_hi_q <= sync_hi_d;
            sync_lo_q <= sync_lo_d;
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        if (hit(bus.rd_addr, cfg_regs_pkg::PIN_ZERO_OUTPUT_CONFIG_OFS))
            bus.rd_data = pin_cfg_q;
        else if (hit(bus.rd_addr, cfg_regs_pkg::QUEUE_THRESHOLD_CONFIG_OFS))
            bus.rd_data = thr_cfg_q;  // upper nibble always zero
        else if (hit(bus.rd_addr, cfg_regs_pkg::SYNC_WORD_HIGH_BYTE_OFS))
            bus.rd_data = sync_hi_q;
        else if (hit(bus.rd_addr, cfg_regs_pkg::SYNC_WORD_LOW_BYTE_OFS))
            bus.rd_data = sync_lo_q;
        else
            bus.rd_data = cfg_regs_pkg::UNMAPPED_READ;
    end

    // ************************************************************
    // crystal divider, pin-zero output, threshold compare
    // ************************************************************
    logic [6:0]         div_cnt_q, div_cnt_d;
    logic               div_clk_q, div_clk_d, pin_q, pin_d;
    logic               tx_hit_q, tx_hit_d, rx_hit_q, rx_hit_d;
    logic [63:0]        sources;
    logic [5:0]         sel;
    logic [COUNT_W-1:0] tx_thr, rx_thr;

    assign sources = {div_clk_q, pin_sources};
    assign sel     = pin_cfg_q[cfg_regs_pkg::SELECT_MSB:0];
    // threshold arithmetic kept at seven bits: rx tops out at 64
    assign tx_thr = COUNT_W'(cfg_regs_pkg::TX_THRESHOLD_BASE
        - cfg_regs_pkg::THRESHOLD_STEP
        * {3'h0, thr_cfg_q[cfg_regs_pkg::THRESHOLD_MSB:0]});
    assign rx_thr = COUNT_W'(cfg_regs_pkg::THRESHOLD_STEP
        * ({3'h0, thr_cfg_q[cfg_regs_pkg::THRESHOLD_MSB:0]}
        + 7'h01));

    always_comb begin
        div_cnt_d = div_cnt_q + 7'h01;
        div_clk_d = div_clk_q;
        if (div_cnt_q == cfg_regs_pkg::DIV_HALF_LAST) begin
            div_cnt_d = 7'h00;
            div_clk_d = ~div_clk_q;  // 50% duty, period 192 clocks
        end
        pin_d    = sources[sel]
                 ^ pin_cfg_q[cfg_regs_pkg::POLARITY_BIT];
        tx_hit_d = tx_queue_count >= tx_thr;
        rx_hit_d = rx_queue_count >= rx_thr;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_q <= 7'h00;
            div_clk_q <= 1'b0;
            pin_q     <= 1'b0;
            tx_hit_q  <= 1'b0;
            rx_hit_q  <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            div_clk_q <= div_clk_d;
            pin_q     <= pin_d;
            tx_hit_q  <= tx_hit_d;
            rx_hit_q  <= rx_hit_d;
        end
    end

    // sensor enable is passed on raw; keeping other bits zero is host duty
    assign temp_sensor_enable = pin_cfg_q[cfg_regs_pkg::TEMP_SENSOR_BIT];
    assign general_output_pin_zero = pin_q;
    assign sync_word        = {sync_hi_q, sync_lo_q};
    assign tx_threshold     = tx_thr;
    assign rx_threshold     = rx_thr;
    assign tx_threshold_hit = tx_hit_q;
    assign rx_threshold_hit = rx_hit_q;

    // ************************************************************
    // checks
    // ************************************************************
    chk_polarity_write: assert property (
        @(posedge clk) disable iff (rst)
        bus.wr_en && bus.wr_addr == cfg_regs_pkg::PIN_ZERO_OUTPUT_CONFIG_OFS
        |=> pin_cfg_q[6] == $past(bus.wr_data[6]))
        else $error("polarity bit not stored");
    chk_select_write: assert property (
        @(posedge clk) disable iff (rst)
        bus.wr_en && bus.wr_addr == cfg_regs_pkg::PIN_ZERO_OUTPUT_CONFIG_OFS
        |=> sel == $past(bus.wr_data[5:0]))
        else $error("select field not stored");
    // divider turns only at the last count, never runs past it
    chk_divider_turn: assert property (
        @(posedge clk) disable iff (rst)
        div_cnt_q <= cfg_regs_pkg::DIV_HALF_LAST
        && ($changed(div_clk_q)
            == ($past(div_cnt_q) == cfg_regs_pkg::DIV_HALF_LAST)))
        else $error("crystal divider turned at wrong count");
    chk_reserved_zero: assert property (
        @(posedge clk) disable iff (rst)
        thr_cfg_q[7:4] == 4'h0)
        else $error("reserved threshold bits not zero");
    chk_threshold_write: assert property (
        @(posedge clk) disable iff (rst)
        bus.wr_en && bus.wr_addr == cfg_regs_pkg::QUEUE_THRESHOLD_CONFIG_OFS
        |=> thr_cfg_q[3:0] == $past(bus.wr_data[3:0]))
        else $error("threshold field not stored");
    chk_tx_level: assert property (
        @(posedge clk) disable iff (rst)
        tx_thr + 7'h04 * {3'h0, thr_cfg_q[3:0]} == 7'h3d)
        else $error("tx threshold wrong");
    chk_rx_level: assert property (
        @(posedge clk) disable iff (rst)
        rx_thr - 7'h04 * {3'h0, thr_cfg_q[3:0]} == 7'h04
        && rx_thr <= 7'h40)
        else $error("rx threshold wrong");
    chk_tx_compare: assert property (
        @(posedge clk) disable iff (rst)
        ##1 tx_hit_q == ($past(tx_queue_count) >= $past(tx_thr)))
        else $error("tx threshold flag wrong");
    chk_rx_compare: assert property (
        @(posedge clk) disable iff (rst)
        ##1 rx_hit_q == ($past(rx_queue_count) >= $past(rx_thr)))
        else $error("rx threshold flag wrong");
    chk_sync_high: assert property (
        @(posedge clk) disable iff (rst)
        bus.wr_en && bus.wr_addr == cfg_regs_pkg::SYNC_WORD_HIGH_BYTE_OFS
        |=> sync_word[15:8] == $past(bus.wr_data))
        else $error("sync high byte not stored");
    chk_sync_low: assert property (
        @(posedge clk) disable iff (rst)
        bus.wr_en && bus.wr_addr == cfg_regs_pkg::SYNC_WORD_LOW_BYTE_OFS
        |=> sync_word[7:0] == $past(bus.wr_data))
        else $error("sync low byte not stored");
    // write lands one edge after the strobe, the pin one edge later
    chk_pin_follow: assert property (
        @(posedge clk) disable iff (rst)
        bus.wr_en && bus.wr_addr == cfg_regs_pkg::PIN_ZERO_OUTPUT_CONFIG_OFS
        |=> ##1 general_output_pin_zero
            == ($past(sources[bus.wr_data[5:0]], 1)
            ^ $past(bus.wr_data[6], 2)))
        else $error("pin zero does not follow new setting");

endmodule // pin0_fifo_threshold_sync_regs

// [tb/host_model.sv]
// host model: drives the serial configuration port as a microcontroller
// assumes mode 0 framing and the bank clock for pacing its pin changes
`timescale 1ns/1ns
module host_model (
    // pacing clock
    input  wire logic clk,
    // serial port pins
    output logic      port_sclk,
    output logic      port_cs_n,
    output logic      port_mosi,
    input  wire logic port_miso
);
    // six clocks a phase leaves margin over the two-flop sync delay
    localparam int HALF = 6;

    // serial clock stands still low outside frames
    initial begin
        port_sclk = 1'b0;
        port_cs_n = 1'b1;
        port_mosi = 1'b0;
    end

    // ****************************************************************
    // one byte, msb first; miso taken just before each rising edge
    // ****************************************************************
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            port_mosi <= tx[i];
            repeat (HALF) @(posedge clk);
            rx[i] = port_miso;
            port_sclk <= 1'b1;
            repeat (HALF) @(posedge clk);
            port_sclk <= 1'b0;
        end
    endtask

    // ****************************************************************
    // one frame: header then n data bytes, read bytes left aligned
    // ****************************************************************
    task automatic access(input logic [7:0] hdr, input logic [15:0] wd,
                          input int n, output logic [15:0] rd);
        logic [7:0] b;
        rd = 16'h0000;
        @(posedge clk);
        port_cs_n <= 1'b0;
        repeat (HALF) @(posedge clk);
        xbyte(hdr, b);
        for (int k = 0; k < n; k++) begin
            xbyte(wd[15-8*k -: 8], b);
            rd[15-8*k -: 8] = b;
        end
        repeat (HALF) @(posedge clk);
        port_cs_n <= 1'b1;
        port_mosi <= ~port_mosi; // released line shows no stale level
        repeat (2 * HALF) @(posedge clk);
    endtask
endmodule // host_model

// [tb/test_pin0_fifo_threshold_sync_regs.sv]
// testbench for the pin-zero, queue threshold and sync word bank
// assumes host_model on the serial pins and a register model kept here
`timescale 1ns/1ns
module test_pin0_fifo_threshold_sync_regs;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [62:0] pin_sources = 63'h0;
    logic [6:0]  tx_queue_count = 7'h00;
    logic [6:0]  rx_queue_count = 7'h00;
    logic        port_sclk, port_cs_n, port_mosi, port_miso, port_miso_oe;
    logic        miso_w, pin, sensor, tx_hit, rx_hit;
    logic        miso_last = 1'b0;
    logic [15:0] sync_word;
    logic [6:0]  tx_thr, rx_thr;
    int          m [64];
    int          fail_count = 0;
    int          n_compared = 0;

    always #2 clk = ~clk;

    // undriven miso shows the inverse of its last level
    always @(posedge clk) if (port_miso_oe) miso_last <= port_miso;
    assign miso_w = port_miso_oe ? port_miso : ~miso_last;

    pin0_fifo_threshold_sync_regs #(.COUNT_W(7)) dut (
        .clk(clk), .rst(rst), .port_sclk(port_sclk),
        .port_cs_n(port_cs_n), .port_mosi(port_mosi),
        .port_miso(port_miso), .port_miso_oe(port_miso_oe),
        .pin_sources(pin_sources), .tx_queue_count(tx_queue_count),
        .rx_queue_count(rx_queue_count), .general_output_pin_zero(pin),
        .temp_sensor_enable(sensor), .sync_word(sync_word),
        .tx_threshold(tx_thr), .rx_threshold(rx_thr),
        .tx_threshold_hit(tx_hit), .rx_threshold_hit(rx_hit));

    host_model host (.clk(clk), .port_sclk(port_sclk),
        .port_cs_n(port_cs_n), .port_mosi(port_mosi), .port_miso(miso_w));

    // ****************************************************************
    // comparison, verdict and register access helpers
    // ****************************************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // model keeps only the four mapped places; reserved bits drop
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] r;
        host.access({2'b00, a}, {d, 8'h00}, 1, r);
        if (a >= 2 && a <= 5) m[a] = (a == 3) ? d % 16 : d;
    endtask

    task automatic rd_chk(input logic [5:0] a);
        logic [15:0] r;
        host.access({2'b10, a}, 16'h0000, 1, r);
        check(r[15:8], 16'(m[a]), "register read");
    endtask

    // decoded outputs against the model
    task automatic outs();
        #1;
        check(sync_word, 16'(m[4] * 256 + m[5]), "sync word");
        check(16'(tx_thr), 16'(61 - 4 * m[3]), "tx level");
        check(16'(rx_thr), 16'(4 * (m[3] + 1)), "rx level");
        check(16'(sensor), 16'(m[2] / 128), "sensor");
    endtask

    task automatic hits(input int t, input int r);
        @(posedge clk);
        tx_queue_count <= 7'(t);
        rx_queue_count <= 7'(r);
        repeat (2) @(posedge clk);
        #1;
        check(16'(tx_hit), 16'(t >= 61 - 4 * m[3]), "tx hit");
        check(16'(rx_hit), 16'(r >= 4 * (m[3] + 1)), "rx hit");
    endtask

    // sources change every clock; pin follows the previous clock's value
    task automatic pin_run(input logic [7:0] v);
        logic [62:0] prev;
        wr(6'h02, v);
        outs();
        prev = pin_sources;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            pin_sources <= 63'({$urandom, $urandom});
            #1;
            check(16'(pin), 16'(prev[v[5:0]] ^ v[6]), "pin");
            prev = pin_sources;
        end
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        int t0;
        logic [15:0] r;
        logic [7:0] h, l;
        logic p;
        foreach (m[i]) m[i] = 0;
        m[2] = 8'h3f;
        m[3] = 8'h07;
        m[4] = 8'hd3;
        m[5] = 8'h91;
        void'($urandom(24299));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        outs();
        for (int a = 2; a <= 5; a++) rd_chk(6'(a));
        rd_chk(6'h10);
        check(16'(port_miso_oe), 16'h0000, "miso idle");
        $display("test reset values done");

        // divider on code 63 toggles every 96 clocks
        p = pin;
        t0 = 0;
        while (pin === p && t0 < 300) begin
            @(posedge clk);
            #1;
            t0++;
        end
        p = pin;
        t0 = 0;
        while (pin === p && t0 < 300) begin
            @(posedge clk);
            #1;
            t0++;
        end
        check(16'(t0), 16'(192 / 2), "divider half");
        $display("test divider done");

        // random selects and both polarities, then sensor mode
        pin_run(8'h7e);
        pin_run(8'h00);
        for (int i = 0; i < 6; i++)
            pin_run({1'b0, 1'(i), 6'($urandom_range(62))});
        pin_run(8'h80);
        $display("test pin output done");

        // every threshold setting with junk in the reserved bits
        for (int n = 0; n < 16; n++) begin
            wr(6'h03, {4'($urandom), 4'(n)});
            rd_chk(6'h03);
            outs();
            hits(60 - 4 * n, 3 + 4 * n);
            hits(61 - 4 * n, 4 + 4 * n);
            hits($urandom_range(64), $urandom_range(64));
        end
        $display("test thresholds done");

        // single writes, unmapped write, burst write and burst read
        for (int i = 0; i < 3; i++) begin
            wr(6'h04, 8'($urandom));
            wr(6'h05, 8'($urandom));
            rd_chk(6'h04);
            rd_chk(6'h05);
            outs();
        end
        wr(6'h10, 8'h5a);
        rd_chk(6'h10);
        h = 8'($urandom);
        l = 8'($urandom);
        host.access(8'h44, {h, l}, 2, r);
        m[4] = h;
        m[5] = l;
        host.access(8'hc4, 16'h0000, 2, r);
        check(r, {h, l}, "burst read");
        outs();
        $display("test sync word done");
        report_and_stop();
    end

    // watchdog well beyond the expected run length
    initial begin
        #200000;
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule // test_pin0_fifo_threshold_sync_regs
